// ---- common/motion_supervisor_pkg.sv ----
package motion_supervisor_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned TICK_MS         = 1;
  localparam int unsigned CYCLES_PER_MS   = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int unsigned OVERHEAT_DEG_C  = 125;
  localparam logic [11:0] OVERHEAT_LIMIT  = 12'(OVERHEAT_DEG_C);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_LEFT_POS  = 8'h04;
  localparam logic [7:0] OFS_RIGHT_POS = 8'h08;
  localparam logic [7:0] OFS_SUP_I_MAX = 8'h0C;
  localparam logic [7:0] OFS_SUP_V_MAX = 8'h10;
  localparam logic [7:0] OFS_USB_I_MAX = 8'h14;
  localparam logic [7:0] OFS_USB_V_MAX = 8'h18;
  localparam logic [7:0] OFS_USB_V_MIN = 8'h1C;
  localparam logic [7:0] OFS_TEMP_MAX  = 8'h20;
  localparam logic [7:0] OFS_LOW_V_OFF = 8'h24;
  localparam logic [7:0] OFS_HOLD      = 8'h28;
  localparam logic [7:0] OFS_OFF_DELAY = 8'h2C;
  localparam logic [7:0] OFS_RAMP_TIME = 8'h30;
  localparam logic [7:0] OFS_STATUS    = 8'h34;
  localparam logic [7:0] OFS_CMD       = 8'h38;
  localparam logic [7:0] OFS_POSITION  = 8'h3C;

  // Control register bit positions
  localparam int unsigned CB_BY_SWITCH   = 0;
  localparam int unsigned CB_SW1_CLOSED  = 1;
  localparam int unsigned CB_SW1_RIGHT   = 2;
  localparam int unsigned CB_SW2_CLOSED  = 3;
  localparam int unsigned CB_SW2_RIGHT   = 4;
  localparam int unsigned CB_STOP_LEFT   = 5;
  localparam int unsigned CB_STOP_RIGHT  = 6;
  localparam int unsigned CB_MISSET_DET  = 7;
  localparam int unsigned CB_LOW_V_EN    = 8;
  localparam int unsigned CB_HEAT_EN     = 9;
  localparam int unsigned CB_BRIDGE_EN   = 10;
  localparam int unsigned CB_MISSET_ALM  = 11;
  localparam int unsigned CB_STICKY      = 12;
  localparam int unsigned CB_USB_RECON   = 13;
  localparam int unsigned CB_CUR_RED_EN  = 14;
  localparam int unsigned CB_PWR_OFF_EN  = 15;
  localparam int unsigned CB_JERK_FREE   = 16;
  localparam int unsigned CTRL_W         = 17;

  localparam logic [CTRL_W-1:0] CTRL_RESET  = 17'h0_0000;
  localparam logic [31:0]       LEFT_RESET  = 32'hFFFF_FC18;
  localparam logic [31:0]       RIGHT_RESET = 32'h0000_03E8;
  localparam logic [11:0]       LIMIT_RESET = 12'hFFF;
  localparam logic [11:0]       MIN_RESET   = 12'h000;
  localparam logic [6:0]        HOLD_PCT_RESET   = 7'h64;
  localparam logic [15:0]       DELAY_RESET      = 16'h0000;
  localparam logic [6:0]        PCT_FULL         = 7'h64;

  // Command register: bit 0 stop, bit 1 move left, bit 2 move right
  localparam int unsigned CMD_STOP  = 0;
  localparam int unsigned CMD_LEFT  = 1;
  localparam int unsigned CMD_RIGHT = 2;

  // Alarm cause bit positions
  localparam int unsigned AC_SUP_I  = 0;
  localparam int unsigned AC_SUP_V  = 1;
  localparam int unsigned AC_USB_I  = 2;
  localparam int unsigned AC_USB_V  = 3;
  localparam int unsigned AC_TEMP   = 4;
  localparam int unsigned AC_LOW_V  = 5;
  localparam int unsigned AC_HEAT   = 6;
  localparam int unsigned AC_BRIDGE = 7;
  localparam int unsigned AC_MISSET = 8;
  localparam int unsigned AC_W      = 9;

  typedef enum logic [2:0] {
    MOT_STOPPED = 3'b001,
    MOT_LEFT    = 3'b010,
    MOT_RIGHT   = 3'b100
  } motion_e;

  typedef struct packed {
    logic [11:0] sup_i;
    logic [11:0] sup_v;
    logic [11:0] usb_i;
    logic [11:0] usb_v;
    logic [11:0] board_t;
    logic [11:0] driver_t;
  } sensors_s;

endpackage

// ---- design/ms_tick_divider.sv ----
`timescale 1ns/1ps
module ms_tick_divider #(
  parameter int unsigned DIV = 10000
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // One-cycle enable
  output logic      tick
);
  logic [$clog2(DIV)-1:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q == ($clog2(DIV))'(DIV - 1)) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule

// ---- design/current_ramp.sv ----
`timescale 1ns/1ps
module current_ramp (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       ms_tick,
  input  wire logic       smooth,
  input  wire logic [15:0] ramp_ms,
  input  wire logic [6:0] target,
  // Output
  output logic      [6:0] level
);
  logic [15:0] step_cnt_q;
  logic [15:0] step_ms;

  // Ms per percent step is ramp_ms/100, each step takes step_ms + 1 ms, so a 0..100 swing takes about ramp_ms + 100 ms
  assign step_ms = ramp_ms / 16'(100);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level      <= 7'h00;
      step_cnt_q <= 16'h0000;
    end else if (!smooth || level == target) begin
      level      <= target;
      step_cnt_q <= 16'h0000;
    end else if (ms_tick) begin
      if (step_cnt_q >= step_ms) begin
        step_cnt_q <= 16'h0000;
        level      <= (level < target) ? level + 7'h01 : level - 7'h01;
      end else begin
        step_cnt_q <= step_cnt_q + 16'h0001;
      end
    end
  end
endmodule

// ---- design/motion_limit_protection_supervisor.sv ----
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module motion_limit_protection_supervisor
  import motion_supervisor_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Stage inputs
  input  wire logic                          sw1_closed,
  input  wire logic                          sw2_closed,
  input  wire logic                          step_pulse,
  input  wire motion_supervisor_pkg::sensors_s sensors,
  input  wire logic                          bridge_fault,
  input  wire logic                          usb_link_up,
  // Power stage outputs
  output logic                               step_en,
  output logic                               step_dir_right,
  output logic                               power_en,
  output logic      [6:0]                    current_pct,
  output logic                               alarm,
  output logic                               usb_reset
);
  import motion_supervisor_pkg::*;

  logic [CTRL_W-1:0] ctrl_q;
  logic [31:0]       left_pos_q;
  logic [31:0]       right_pos_q;
  logic [11:0]       sup_i_max_q;
  logic [11:0]       sup_v_max_q;
  logic [11:0]       usb_i_max_q;
  logic [11:0]       usb_v_max_q;
  logic [11:0]       usb_v_min_q;
  logic [11:0]       temp_max_q;
  logic [11:0]       low_v_off_q;
  logic [6:0]        hold_pct_q;
  logic [15:0]       red_delay_q;
  logic [15:0]       off_delay_q;
  logic [15:0]       ramp_ms_q;
  logic [31:0]       position_q;
  motion_e           motion_q;
  logic [AC_W-1:0]   cause_q;
  logic [AC_W-1:0]   cause_now;
  logic              alarm_q;
  logic              usb_up_q;
  logic [15:0]       stop_ms_q;
  logic [9:0]        ms_in_s_q;
  logic [15:0]       stop_s_q;
  logic              ms_tick;
  logic              wr_en;
  logic              rd_en;
  logic              stop_cmd;
  logic              left_cmd;
  logic              right_cmd;
  logic              sw1_hit;
  logic              sw2_hit;
  logic              left_hit;
  logic              right_hit;
  logic              left_sw;
  logic              right_sw;
  logic              left_block;
  logic              right_block;
  logic              reduced;
  logic              powered_off;
  logic [6:0]        target_pct;
  logic [6:0]        ramp_level;

  assign wr_en     = psel && penable && pwrite;
  assign rd_en     = psel && !penable && !pwrite;
  assign stop_cmd  = wr_en && paddr == OFS_CMD && pwdata[CMD_STOP];
  assign left_cmd  = wr_en && paddr == OFS_CMD && pwdata[CMD_LEFT];
  assign right_cmd = wr_en && paddr == OFS_CMD && pwdata[CMD_RIGHT];

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= CTRL_RESET;
      left_pos_q  <= LEFT_RESET;
      right_pos_q <= RIGHT_RESET;
      sup_i_max_q <= LIMIT_RESET;
      sup_v_max_q <= LIMIT_RESET;
      usb_i_max_q <= LIMIT_RESET;
      usb_v_max_q <= LIMIT_RESET;
      usb_v_min_q <= MIN_RESET;
      temp_max_q  <= LIMIT_RESET;
      low_v_off_q <= MIN_RESET;
      hold_pct_q  <= HOLD_PCT_RESET;
      red_delay_q <= DELAY_RESET;
      off_delay_q <= DELAY_RESET;
      ramp_ms_q   <= DELAY_RESET;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL:      ctrl_q      <= pwdata[CTRL_W-1:0];
        OFS_LEFT_POS:  left_pos_q  <= pwdata;
        OFS_RIGHT_POS: right_pos_q <= pwdata;
        OFS_SUP_I_MAX: sup_i_max_q <= pwdata[11:0];
        OFS_SUP_V_MAX: sup_v_max_q <= pwdata[11:0];
        OFS_USB_I_MAX: usb_i_max_q <= pwdata[11:0];
        OFS_USB_V_MAX: usb_v_max_q <= pwdata[11:0];
        OFS_USB_V_MIN: usb_v_min_q <= pwdata[11:0];
        OFS_TEMP_MAX:  temp_max_q  <= pwdata[11:0];
        OFS_LOW_V_OFF: low_v_off_q <= pwdata[11:0];
        OFS_HOLD: begin
          red_delay_q <= pwdata[31:16];
          hold_pct_q  <= (pwdata[6:0] > PCT_FULL) ? PCT_FULL : pwdata[6:0];
        end
        OFS_OFF_DELAY: off_delay_q <= pwdata[15:0];
        OFS_RAMP_TIME: ramp_ms_q   <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // APB read path, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= paddr[1:0] != 2'h0 || paddr > OFS_POSITION;
      end
      if (rd_en) begin
        case (paddr)
          OFS_CTRL:      prdata <= 32'(ctrl_q);
          OFS_LEFT_POS:  prdata <= left_pos_q;
          OFS_RIGHT_POS: prdata <= right_pos_q;
          OFS_SUP_I_MAX: prdata <= 32'(sup_i_max_q);
          OFS_SUP_V_MAX: prdata <= 32'(sup_v_max_q);
          OFS_USB_I_MAX: prdata <= 32'(usb_i_max_q);
          OFS_USB_V_MAX: prdata <= 32'(usb_v_max_q);
          OFS_USB_V_MIN: prdata <= 32'(usb_v_min_q);
          OFS_TEMP_MAX:  prdata <= 32'(temp_max_q);
          OFS_LOW_V_OFF: prdata <= 32'(low_v_off_q);
          OFS_HOLD:      prdata <= {red_delay_q, 9'h000, hold_pct_q};
          OFS_OFF_DELAY: prdata <= 32'(off_delay_q);
          OFS_RAMP_TIME: prdata <= 32'(ramp_ms_q);
          OFS_STATUS:    prdata <= {10'h000, current_pct, left_hit, right_hit, motion_q, alarm_q, cause_q};
          OFS_POSITION:  prdata <= position_q;
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Switch polarity and side mapping
  assign sw1_hit  = ctrl_q[CB_SW1_CLOSED] ? sw1_closed : !sw1_closed;
  assign sw2_hit  = ctrl_q[CB_SW2_CLOSED] ? sw2_closed : !sw2_closed;
  assign left_sw  = (!ctrl_q[CB_SW1_RIGHT] && sw1_hit) || (!ctrl_q[CB_SW2_RIGHT] && sw2_hit);
  assign right_sw = (ctrl_q[CB_SW1_RIGHT] && sw1_hit) || (ctrl_q[CB_SW2_RIGHT] && sw2_hit);

  // Border reached, by switch or by position
  always_comb begin
    if (ctrl_q[CB_BY_SWITCH]) begin
      left_hit  = left_sw;
      right_hit = right_sw;
    end else begin
      left_hit  = $signed(position_q) <= $signed(left_pos_q);
      right_hit = $signed(position_q) >= $signed(right_pos_q);
    end
  end

  assign left_block  = left_hit && (ctrl_q[CB_STOP_LEFT] || ctrl_q[CB_MISSET_DET]);
  assign right_block = right_hit && (ctrl_q[CB_STOP_RIGHT] || ctrl_q[CB_MISSET_DET]);

  // Alarm causes present now
  always_comb begin
    cause_now            = '0;
    cause_now[AC_SUP_I]  = sensors.sup_i > sup_i_max_q;
    cause_now[AC_SUP_V]  = sensors.sup_v > sup_v_max_q;
    cause_now[AC_USB_I]  = sensors.usb_i > usb_i_max_q;
    cause_now[AC_USB_V]  = sensors.usb_v > usb_v_max_q || sensors.usb_v < usb_v_min_q;
    cause_now[AC_TEMP]   = sensors.board_t > temp_max_q;
    cause_now[AC_LOW_V]  = ctrl_q[CB_LOW_V_EN] && sensors.sup_v <= low_v_off_q;
    cause_now[AC_HEAT]   = ctrl_q[CB_HEAT_EN] && sensors.driver_t > OVERHEAT_LIMIT;
    cause_now[AC_BRIDGE] = ctrl_q[CB_BRIDGE_EN] && bridge_fault;
    cause_now[AC_MISSET] = ctrl_q[CB_MISSET_ALM] && ctrl_q[CB_BY_SWITCH]
                           && ((motion_q == MOT_LEFT && right_sw)
                               || (motion_q == MOT_RIGHT && left_sw));
  end

  // Alarm cause tracking; new causes win over a Stop clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= '0;
      alarm_q <= 1'b0;
    end else if (ctrl_q[CB_STICKY]) begin
      cause_q <= (stop_cmd ? '0 : cause_q) | cause_now;
      alarm_q <= (stop_cmd ? 1'b0 : alarm_q) || (|cause_now);
    end else begin
      cause_q <= cause_now;
      alarm_q <= |cause_now;
    end
  end

  // Motion state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motion_q <= MOT_STOPPED;
    end else begin
      case (motion_q)
        MOT_STOPPED: begin
          if (alarm_q) begin
            motion_q <= MOT_STOPPED;
          end else if (left_cmd && !left_block) begin
            motion_q <= MOT_LEFT;
          end else if (right_cmd && !right_block) begin
            motion_q <= MOT_RIGHT;
          end
        end
        MOT_LEFT: begin
          if (alarm_q || stop_cmd || left_block) begin
            motion_q <= MOT_STOPPED;
          end else if (right_cmd && !right_block) begin
            motion_q <= MOT_RIGHT;
          end
        end
        MOT_RIGHT: begin
          if (alarm_q || stop_cmd || right_block) begin
            motion_q <= MOT_STOPPED;
          end else if (left_cmd && !left_block) begin
            motion_q <= MOT_LEFT;
          end
        end
        default: motion_q <= MOT_STOPPED;
      endcase
    end
  end

  // Step position counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position_q <= 32'h0000_0000;
    end else if (wr_en && paddr == OFS_POSITION) begin
      position_q <= pwdata;
    end else if (step_pulse && motion_q == MOT_RIGHT) begin
      position_q <= position_q + 32'h0000_0001;
    end else if (step_pulse && motion_q == MOT_LEFT) begin
      position_q <= position_q - 32'h0000_0001;
    end
  end

  ms_tick_divider #(
    .DIV (MS_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (ms_tick)
  );

  // Time spent stopped, in ms and s
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_ms_q <= 16'h0000;
      ms_in_s_q <= 10'h000;
      stop_s_q  <= 16'h0000;
    end else if (motion_q != MOT_STOPPED) begin
      stop_ms_q <= 16'h0000;
      ms_in_s_q <= 10'h000;
      stop_s_q  <= 16'h0000;
    end else if (ms_tick) begin
      if (stop_ms_q != 16'hFFFF) begin
        stop_ms_q <= stop_ms_q + 16'h0001;
      end
      if (ms_in_s_q == 10'(MS_PER_S - 1)) begin
        ms_in_s_q <= 10'h000;
        if (stop_s_q != 16'hFFFF) begin
          stop_s_q <= stop_s_q + 16'h0001;
        end
      end else begin
        ms_in_s_q <= ms_in_s_q + 10'h001;
      end
    end
  end

  assign reduced     = ctrl_q[CB_CUR_RED_EN] && motion_q == MOT_STOPPED && stop_ms_q >= red_delay_q;
  assign powered_off = ctrl_q[CB_PWR_OFF_EN] && motion_q == MOT_STOPPED && stop_s_q >= off_delay_q;
  assign target_pct  = reduced ? hold_pct_q : PCT_FULL;

  current_ramp u_ramp (
    .pclk    (pclk),
    .presetn (presetn),
    .ms_tick (ms_tick),
    .smooth  (ctrl_q[CB_JERK_FREE]),
    .ramp_ms (ramp_ms_q),
    .target  (target_pct),
    .level   (ramp_level)
  );

  // Power stage outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_en        <= 1'b0;
      step_dir_right <= 1'b0;
      power_en       <= 1'b0;
      current_pct    <= 7'h00;
      alarm          <= 1'b0;
    end else begin
      step_en        <= motion_q != MOT_STOPPED && !alarm_q;
      step_dir_right <= motion_q == MOT_RIGHT;
      power_en       <= !alarm_q && !(|cause_now) && !powered_off;
      current_pct    <= (alarm_q || powered_off) ? 7'h00 : ramp_level;
      alarm          <= alarm_q;
    end
  end

  // USB link break detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_up_q  <= 1'b0;
      usb_reset <= 1'b0;
    end else begin
      usb_up_q  <= usb_link_up;
      usb_reset <= ctrl_q[CB_USB_RECON] && usb_up_q && !usb_link_up;
    end
  end

endmodule

// ---- verification/motion_supervisor_asserts.sv ----
`timescale 1ns/1ps
module motion_supervisor_asserts
  import motion_supervisor_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic                            pclk,
  input wire logic                            presetn,
  // APB
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [7:0]                      paddr,
  input wire logic [31:0]                     pwdata,
  input wire logic                            pready,
  // Stage side
  input wire motion_supervisor_pkg::sensors_s sensors,
  input wire logic                            bridge_fault,
  input wire logic                            usb_link_up,
  input wire logic                            step_en,
  input wire logic                            power_en,
  input wire logic [6:0]                      current_pct,
  input wire logic                            alarm,
  input wire logic                            usb_reset
);
  import motion_supervisor_pkg::*;
  logic [CTRL_W-1:0] ctrl_q;
  // Mirror of the control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_q <= CTRL_RESET;
    else if (psel && penable && pready && pwrite && paddr == OFS_CTRL)
      ctrl_q <= pwdata[CTRL_W-1:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  zero_wait_a: assert property (psel && penable |-> pready) else $error("access not answered");
  heat_alarm_a: assert property ((ctrl_q[CB_HEAT_EN] && sensors.driver_t > OVERHEAT_LIMIT) [*3] |-> alarm)
    else $error("overheat without alarm");
  bridge_alarm_a: assert property ((ctrl_q[CB_BRIDGE_EN] && bridge_fault) [*3] |-> alarm)
    else $error("bridge fault without alarm");
  usb_pulse_a: assert property ($fell(usb_link_up) && ctrl_q[CB_USB_RECON] |-> ##[1:3] usb_reset)
    else $error("no usb reset on link break");
  alarm_power_a: assert property ($rose(alarm) |-> !power_en)
    else $error("power on during alarm");
  alarm_move_a: assert property (alarm [*2] |-> !step_en)
    else $error("motion during alarm");
  pct_range_a: assert property (current_pct <= PCT_FULL)
    else $error("current above full scale");
  cover property ($rose(alarm));
  cover property (usb_reset);
  cover property ($fell(step_en));
endmodule
bind motion_limit_protection_supervisor motion_supervisor_asserts #(.MS_CYCLES(MS_CYCLES)) asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .sensors(sensors), .bridge_fault(bridge_fault),
  .usb_link_up(usb_link_up), .step_en(step_en), .power_en(power_en), .current_pct(current_pct),
  .alarm(alarm), .usb_reset(usb_reset));

// ---- verification/stage_model.sv ----
`timescale 1ns/1ps
module stage_model #(
  parameter int STEP_GAP = 4,
  parameter int SW_AT    = 6
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Drive from the block
  input  wire logic step_en,
  input  wire logic step_dir_right,
  input  wire logic power_en,
  // Stage feedback
  output logic      step_pulse,
  output logic      sw1_closed,
  output logic      sw2_closed
);
  int pos;
  int gap;
  // One step per STEP_GAP cycles while driven and powered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 0;
      gap <= 0;
      step_pulse <= 1'b0;
    end else begin
      step_pulse <= 1'b0;
      gap <= (step_en && power_en) ? gap + 1 : 0;
      if (step_en && power_en && gap == STEP_GAP - 1) begin
        step_pulse <= 1'b1;
        gap <= 0;
        pos <= step_dir_right ? pos + 1 : pos - 1;
      end
    end
  end
  // Contacts close at the travel ends
  assign sw1_closed = pos <= -SW_AT;
  assign sw2_closed = pos >= SW_AT;
endmodule

// ---- verification/motion_limit_protection_supervisor_tb.sv ----
`timescale 1ns/1ps
module motion_limit_protection_supervisor_tb;
  import motion_supervisor_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        bridge_fault, usb_link_up, step_en, step_dir_right, power_en;
  logic        alarm, usb_reset, step_pulse, sw1_closed, sw2_closed;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  current_pct;
  sensors_s    sens;
  int          mismatches, num_checks, cyc;
  logic [7:0]  ofs [5] = '{OFS_SUP_I_MAX, OFS_SUP_V_MAX, OFS_USB_I_MAX, OFS_USB_V_MAX, OFS_TEMP_MAX};
  motion_limit_protection_supervisor #(.MS_CYCLES(10)) motion_limit_protection_supervisor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sw1_closed(sw1_closed),
    .sw2_closed(sw2_closed), .step_pulse(step_pulse), .sensors(sens), .bridge_fault(bridge_fault),
    .usb_link_up(usb_link_up), .step_en(step_en), .step_dir_right(step_dir_right), .power_en(power_en),
    .current_pct(current_pct), .alarm(alarm), .usb_reset(usb_reset));
  stage_model stage_model_i (.pclk(pclk), .presetn(presetn), .step_en(step_en), .step_dir_right(step_dir_right),
    .power_en(power_en), .step_pulse(step_pulse), .sw1_closed(sw1_closed), .sw2_closed(sw2_closed));
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the edge that samples pready high
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Alarm flag, one cause bit and the power stage
  task automatic stat(input logic a, input int cb);
    idle(4);
    apb(1'b0, OFS_STATUS, 0);
    chk("alarm", 32'(rd[9]), 32'(a));
    chk("cause", 32'(rd[cb]), 32'(a));
    chk("power_en", 32'(power_en), 32'(!a));
    chk("alarm pin", 32'(alarm), 32'(a));
  endtask
  initial begin
    int n, lim, hp;
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, bridge_fault, paddr, pwdata} = '0;
    usb_link_up = 1;
    sens = '0;
    void'($urandom(32'h3D55));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    idle(2);
    apb(0, OFS_LEFT_POS, 0); chk("left", rd, LEFT_RESET);
    apb(0, OFS_RIGHT_POS, 0); chk("right", rd, RIGHT_RESET);
    apb(0, 8'h40, 0); chk("slverr", 32'(err), 1);
    $display("reset test done");
    apb(1, OFS_POSITION, 996);
    apb(1, OFS_CTRL, 32'h40);
    apb(1, OFS_CMD, 4); idle(60);
    apb(0, OFS_POSITION, 0); chk("pos", rd, RIGHT_RESET);
    apb(0, OFS_STATUS, 0); chk("status", 32'(rd[13:10]), 32'h9);
    apb(1, OFS_CMD, 4); idle(20); chk("ignored", 32'(step_en), 0);
    apb(1, OFS_CMD, 2); idle(2); chk("leaving", 32'(step_en), 1);
    chk("dir left", 32'(step_dir_right), 0);
    apb(1, OFS_CMD, 1);
    $display("position test done");
    apb(1, OFS_CTRL, 32'h7B);
    apb(1, OFS_CMD, 2); idle(80); chk("sw stop", 32'(step_en), 0);
    apb(0, OFS_STATUS, 0); chk("left hit", 32'(rd[14]), 1);
    apb(1, OFS_CTRL, 32'h79);
    apb(1, OFS_CMD, 2); idle(2); chk("sw open", 32'(step_en), 1);
    apb(1, OFS_CMD, 1);
    apb(1, OFS_CTRL, 32'h9B);
    apb(1, OFS_CMD, 2); idle(20); chk("misset stop", 32'(step_en), 0);
    // Left-end switch set up as right: moving left trips it
    apb(1, OFS_CTRL, 32'h180F);
    apb(1, OFS_CMD, 2);
    stat(1, AC_MISSET);
    apb(1, OFS_CMD, 1);
    apb(1, OFS_CTRL, 0);
    $display("switch test done");
    foreach (ofs[k]) begin
      lim = 100 + $urandom % 3000;
      apb(1, ofs[k], lim);
      sens[71-12*k -: 12] <= 12'(lim + 1);
      stat(1, k);
      sens[71-12*k -: 12] <= 12'(lim);
      stat(0, k);
      apb(1, ofs[k], 32'hFFF);
    end
    apb(1, OFS_CTRL, 32'h300);
    apb(1, OFS_LOW_V_OFF, 300);
    sens.sup_v <= 12'd300;
    stat(1, AC_LOW_V);
    sens.sup_v <= 12'd301;
    sens.driver_t <= 12'd125;
    stat(0, AC_HEAT);
    sens.driver_t <= 12'd126;
    stat(1, AC_HEAT);
    sens.driver_t <= 12'd0;
    apb(1, OFS_CTRL, 32'h1400);
    bridge_fault <= 1'b1;
    stat(1, AC_BRIDGE);
    bridge_fault <= 1'b0;
    stat(1, AC_BRIDGE);
    apb(1, OFS_CMD, 1);
    stat(0, AC_BRIDGE);
    $display("alarm test done");
    apb(1, OFS_CTRL, 32'h2000);
    usb_link_up <= 1'b0;
    n = 0;
    while (usb_reset !== 1'b1 && n++ < 6) @(negedge pclk);
    chk("usb_reset", 32'(usb_reset), 1);
    @(posedge pclk);
    usb_link_up <= 1'b1;
    hp = $urandom % 101;
    apb(1, OFS_HOLD, {16'h0003, 9'h0, 7'(hp)});
    apb(1, OFS_CTRL, 32'h4000);
    apb(1, OFS_CMD, 4); idle(4); chk("run pct", 32'(current_pct), 100);
    chk("dir right", 32'(step_dir_right), 1);
    apb(1, OFS_CMD, 1); idle(10); chk("early pct", 32'(current_pct), 100);
    idle(40); chk("hold pct", 32'(current_pct), hp);
    apb(1, OFS_OFF_DELAY, 0);
    apb(1, OFS_CTRL, 32'hC000); idle(5); chk("off", 32'(power_en), 0);
    apb(1, OFS_CTRL, 0); idle(5); chk("on", 32'(power_en), 1);
    // 200 ms set time: one percent per three ms
    apb(1, OFS_RAMP_TIME, 200);
    apb(1, OFS_CTRL, 32'h14000); idle(4); chk("ramp start", 32'(current_pct), 100);
    idle(3100); chk("ramp end", 32'(current_pct), hp);
    $display("power test done");
    tally_and_finish();
  end
endmodule
